// ===== hw/tse_cfg.svh
`ifndef TSE_CFG_SVH
`define TSE_CFG_SVH

// word offsets inside the control area
`define TSE_CTRL_SCREEN    2'h0
`define TSE_CTRL_COPY_SRC  2'h1
`define TSE_CTRL_COPY_DST  2'h2
`define TSE_CTRL_BITS      2'h3
`define TSE_CTRL_LAST      2'h3

// word offsets inside the notify area
`define TSE_NOTE_SCREEN    16'h0000
`define TSE_NOTE_TABLE     16'h0001
`define TSE_NOTE_STATUS    16'h0002

// status word strobe positions
`define TSE_STB_SCREEN     12
`define TSE_STB_NUMERAL    11
`define TSE_STB_MASK       16'h1800

// copy word fields
`define TSE_COPY_TYPE_HI   15
`define TSE_COPY_TYPE_LO   12
`define TSE_COPY_NUM_HI    11
`define TSE_COPY_NUM_LO    0
`define TSE_COPY_TYPE_CHAR 4'h0
`define TSE_COPY_TYPE_NUM  4'h1

`define TSE_SCREEN_NONE    16'h0000
`define TSE_WORD_ZERO      16'h0000

// poll period
`define TSE_CLK_PERIOD_NS  8
`define TSE_POLL_PERIOD_NS 10000
`define TSE_POLL_CYCLES    (`TSE_POLL_PERIOD_NS / `TSE_CLK_PERIOD_NS)
`define TSE_POLL_CNT_W     11

`endif

// ===== hw/tse_pkg.sv
package tse_pkg;

    typedef logic [15:0] tse_word_t;

    typedef enum logic [2:0]
    {
        TSE_IDLE      = 3'b000,
        TSE_RD_CTRL   = 3'b001,
        TSE_RD_ELEM   = 3'b010,
        TSE_WR_SCREEN = 3'b011,
        TSE_WR_VALUE  = 3'b100,
        TSE_WR_TABLE  = 3'b101,
        TSE_WR_STATUS = 3'b110
    } tse_state_t;

endpackage

// ===== hw/tse_poll_timer.sv
`timescale 1ns/1ns
`include "tse_cfg.svh"

// periodic one-cycle enable for the control area poll
module tse_poll_timer
(
    input  wire logic clock_i,
    input  wire logic srst_i,
    output logic      tick_o
);
    import tse_pkg::*;

    localparam logic [`TSE_POLL_CNT_W-1:0] LAST = `TSE_POLL_CNT_W'(`TSE_POLL_CYCLES - 1);

    typedef struct packed
    {
        logic [`TSE_POLL_CNT_W-1:0] cnt;
        logic                       tick;
    } tse_tmr_t;

    tse_tmr_t st_q;
    tse_tmr_t st_d;

    always_comb
    begin
        st_d      = st_q;
        st_d.tick = 1'b0;
        if (st_q.cnt == LAST)
        begin
            st_d.cnt  = '0;
            st_d.tick = 1'b1;
        end
        else
        begin
            st_d.cnt = st_q.cnt + 1'b1;
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign tick_o = st_q.tick;
endmodule

// ===== hw/tse_exchange.sv
`timescale 1ns/1ns
`include "tse_cfg.svh"

// Notes on behaviour
// - poll display element word from host and show returned value.
// - control word 0 holds the requested screen as four BCD digits.
// - word 1 copy source, word 2 copy type and destination, three BCD digits.
// - copy type 0 is character-string table, 1 is numeral table.
// - control word 3 holds host-driven control bits such as backlight.
// - new control area content is read and its operation carried out.
// - screen change writes notify word 0 and sets the screen strobe together.
// - strobes return to 0 once the host has been notified.
// - numeral key entry writes table number and sets numeral strobe.
// - numeral key entry also updates the table's host word.
// - character-string tables produce table and numeral-strobe notices only when entered in the ack cycle of a numeral entry's value write.
// - operating status bits go into notify word 2.
// - changed table values and system keys are written back to host words.
// - area bases are configuration loaded into the terminal, not runtime.
// - host-requested screen switches only when the request word changes; 0000 re-arms.
module tse_exchange
(
    input  wire logic           clock_i,
    input  wire logic           srst_i,
    input  tse_pkg::tse_word_t  ctrl_base_i,
    input  tse_pkg::tse_word_t  notify_base_i,
    input  tse_pkg::tse_word_t  elem_addr_i,
    input  tse_pkg::tse_word_t  status_bits_i,
    input  wire logic           menu_valid_i,
    input  tse_pkg::tse_word_t  menu_screen_i,
    input  wire logic           key_valid_i,
    input  wire logic           key_numeral_i,
    input  tse_pkg::tse_word_t  key_table_i,
    input  tse_pkg::tse_word_t  key_addr_i,
    input  tse_pkg::tse_word_t  key_value_i,
    input  wire logic           host_ack_i,
    input  tse_pkg::tse_word_t  host_rdata_i,
    output logic                host_req_o,
    output logic                host_write_o,
    output tse_pkg::tse_word_t  host_addr_o,
    output tse_pkg::tse_word_t  host_wdata_o,
    output tse_pkg::tse_word_t  shown_screen_o,
    output logic                screen_switch_o,
    output logic                copy_req_o,
    output logic [3:0]          copy_type_o,
    output logic [11:0]         copy_src_o,
    output logic [11:0]         copy_dst_o,
    output tse_pkg::tse_word_t  ctrl_bits_o,
    output tse_pkg::tse_word_t  elem_value_o
);
    import tse_pkg::*;

    typedef struct packed
    {
        tse_state_t      state;
        logic [1:0]      idx;
        tse_word_t [3:0] ctrl;
        logic            copy_chg;
        tse_word_t       ctrl_base;
        tse_word_t       notify_base;
        tse_word_t       shown;
        tse_word_t       table_num;
        logic            scr_pend;
        logic            key_pend;
        logic            key_numeral;
        tse_word_t       key_table;
        tse_word_t       key_addr;
        tse_word_t       key_value;
        logic            stb_scr;
        logic            stb_num;
        logic            req;
        logic            write;
        tse_word_t       addr;
        tse_word_t       wdata;
        logic            switch_p;
        logic            copy_p;
        logic [3:0]      copy_type;
        logic [11:0]     copy_src;
        logic [11:0]     copy_dst;
        tse_word_t       elem;
    } tse_st_t;

    tse_st_t st_q;
    tse_st_t st_d;
    logic    poll_tick;

    function automatic tse_word_t word_at(input tse_word_t base, input tse_word_t off);
        word_at = base + off;
    endfunction

    tse_poll_timer u_timer
    (
        .clock_i (clock_i),
        .srst_i  (srst_i),
        .tick_o  (poll_tick)
    );

    always_comb
    begin
        st_d          = st_q;
        st_d.switch_p = 1'b0;
        st_d.copy_p   = 1'b0;

        // menu screen change taken as a screen switch
        if (menu_valid_i && menu_screen_i != st_q.shown)
        begin
            st_d.shown    = menu_screen_i;
            st_d.scr_pend = 1'b1;
            st_d.switch_p = 1'b1;
        end

        unique case (st_q.state)
            TSE_IDLE:
            begin
                if (poll_tick)
                begin
                    st_d.state = TSE_RD_CTRL;
                    st_d.idx   = `TSE_CTRL_SCREEN;
                end
            end
            TSE_RD_CTRL:
            begin
                if (!st_q.req)
                begin
                    st_d.req   = 1'b1;
                    st_d.write = 1'b0;
                    st_d.addr  = word_at(st_q.ctrl_base, {14'h0000, st_q.idx});
                end
                else if (host_ack_i)
                begin
                    st_d.req            = 1'b0;
                    st_d.ctrl[st_q.idx] = host_rdata_i;
                    unique case (st_q.idx)
                        `TSE_CTRL_SCREEN:
                        begin
                            if (host_rdata_i != st_q.ctrl[st_q.idx]
                                && host_rdata_i != `TSE_SCREEN_NONE)
                            begin
                                st_d.shown    = host_rdata_i;
                                st_d.scr_pend = 1'b1;
                                st_d.switch_p = 1'b1;
                            end
                        end
                        `TSE_CTRL_COPY_SRC:
                        begin
                            st_d.copy_chg = host_rdata_i != st_q.ctrl[st_q.idx];
                        end
                        `TSE_CTRL_COPY_DST:
                        begin
                            if (st_q.copy_chg || host_rdata_i != st_q.ctrl[st_q.idx])
                            begin
                                st_d.copy_p    = 1'b1;
                                st_d.copy_type = host_rdata_i[`TSE_COPY_TYPE_HI:`TSE_COPY_TYPE_LO];
                                st_d.copy_dst  = host_rdata_i[`TSE_COPY_NUM_HI:`TSE_COPY_NUM_LO];
                                st_d.copy_src  =
                                    st_q.ctrl[`TSE_CTRL_COPY_SRC][`TSE_COPY_NUM_HI:`TSE_COPY_NUM_LO];
                            end
                        end
                        `TSE_CTRL_BITS:
                        begin
                        end
                    endcase
                    if (st_q.idx == `TSE_CTRL_LAST)
                    begin
                        st_d.state = TSE_RD_ELEM;
                    end
                    else
                    begin
                        st_d.idx = st_q.idx + 2'h1;
                    end
                end
            end
            TSE_RD_ELEM:
            begin
                if (!st_q.req)
                begin
                    st_d.req   = 1'b1;
                    st_d.write = 1'b0;
                    st_d.addr  = elem_addr_i;
                end
                else if (host_ack_i)
                begin
                    st_d.req   = 1'b0;
                    st_d.elem  = host_rdata_i;
                    st_d.state = st_q.scr_pend ? TSE_WR_SCREEN
                               : st_q.key_pend ? TSE_WR_VALUE : TSE_WR_STATUS;
                end
            end
            TSE_WR_SCREEN:
            begin
                if (!st_q.req)
                begin
                    st_d.req   = 1'b1;
                    st_d.write = 1'b1;
                    st_d.addr  = word_at(st_q.notify_base, `TSE_NOTE_SCREEN);
                    st_d.wdata = st_q.shown;
                end
                else if (host_ack_i)
                begin
                    st_d.req      = 1'b0;
                    st_d.scr_pend = st_d.switch_p; // fresh switch survives the clear
                    st_d.stb_scr  = 1'b1;
                    st_d.state    = st_q.key_pend ? TSE_WR_VALUE : TSE_WR_STATUS;
                end
            end
            TSE_WR_VALUE:
            begin
                if (!st_q.req)
                begin
                    st_d.req   = 1'b1;
                    st_d.write = 1'b1;
                    st_d.addr  = st_q.key_addr;
                    st_d.wdata = st_q.key_value;
                end
                else if (host_ack_i)
                begin
                    st_d.req   = 1'b0;
                    st_d.state = st_q.key_numeral ? TSE_WR_TABLE : TSE_WR_STATUS;
                    st_d.key_pend = st_q.key_numeral;
                end
            end
            TSE_WR_TABLE:
            begin
                if (!st_q.req)
                begin
                    st_d.req   = 1'b1;
                    st_d.write = 1'b1;
                    st_d.addr  = word_at(st_q.notify_base, `TSE_NOTE_TABLE);
                    st_d.wdata = st_q.key_table;
                end
                else if (host_ack_i)
                begin
                    st_d.req       = 1'b0;
                    st_d.table_num = st_q.key_table;
                    st_d.key_pend  = 1'b0;
                    st_d.stb_num   = 1'b1;
                    st_d.state     = TSE_WR_STATUS;
                end
            end
            TSE_WR_STATUS:
            begin
                if (!st_q.req)
                begin
                    st_d.req   = 1'b1;
                    st_d.write = 1'b1;
                    st_d.addr  = word_at(st_q.notify_base, `TSE_NOTE_STATUS);
                    st_d.wdata = status_bits_i & ~`TSE_STB_MASK;
                    st_d.wdata[`TSE_STB_SCREEN]  = st_q.stb_scr;
                    st_d.wdata[`TSE_STB_NUMERAL] = st_q.stb_num;
                end
                else if (host_ack_i)
                begin
                    st_d.req     = 1'b0;
                    st_d.stb_scr = 1'b0;
                    st_d.stb_num = 1'b0;
                    st_d.state   = TSE_IDLE;
                end
            end
            default:
            begin
                st_d.state = TSE_IDLE;
            end
        endcase

        // key entry capture after the drain so a new entry in the cycle that clears key_pend is not lost
        if (key_valid_i)
        begin
            st_d.key_pend    = 1'b1;
            st_d.key_numeral = key_numeral_i;
            st_d.key_table   = key_table_i;
            st_d.key_addr    = key_addr_i;
            st_d.key_value   = key_value_i;
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            st_q             <= '0;
            st_q.state       <= TSE_IDLE;
            st_q.ctrl_base   <= ctrl_base_i;
            st_q.notify_base <= notify_base_i;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign host_req_o      = st_q.req;
    assign host_write_o    = st_q.write;
    assign host_addr_o     = st_q.addr;
    assign host_wdata_o    = st_q.wdata;
    assign shown_screen_o  = st_q.shown;
    assign screen_switch_o = st_q.switch_p;
    assign copy_req_o      = st_q.copy_p;
    assign copy_type_o     = st_q.copy_type;
    assign copy_src_o      = st_q.copy_src;
    assign copy_dst_o      = st_q.copy_dst;
    assign ctrl_bits_o     = st_q.ctrl[`TSE_CTRL_BITS];
    assign elem_value_o    = st_q.elem;
endmodule

// ===== testbench/tse_sva.sv
`timescale 1ns/1ns
module tse_checker
(
    input  wire logic          clock_i,
    input  wire logic          srst_i,
    input  tse_pkg::tse_word_t ctrl_base_i,
    input  wire logic          host_ack_i,
    input  tse_pkg::tse_word_t host_rdata_i,
    input  wire logic          host_req_o,
    input  wire logic          host_write_o,
    input  tse_pkg::tse_word_t host_addr_o,
    input  tse_pkg::tse_word_t host_wdata_o,
    input  tse_pkg::tse_word_t shown_screen_o,
    input  wire logic          screen_switch_o,
    input  wire logic          copy_req_o
);
    import tse_pkg::*;
    default clocking @(posedge clock_i); endclocking
    default disable iff (srst_i);
    sequence s_done;
        host_req_o && host_ack_i;
    endsequence
    sequence s_rd0;
        s_done ##0 (!host_write_o && host_addr_o == ctrl_base_i);
    endsequence
    property p_hold;
        host_req_o && !host_ack_i |=> host_req_o && $stable(host_addr_o)
            && $stable(host_write_o) && $stable(host_wdata_o);
    endproperty
    property p_drop;
        s_done |=> !host_req_o;
    endproperty
    property p_next;
        s_rd0 |=> ##1 host_req_o && !host_write_o && host_addr_o == ctrl_base_i + 16'h1;
    endproperty
    property p_pulse;
        screen_switch_o |=> !screen_switch_o;
    endproperty
    // a re-armed host request may switch back to the screen already shown
    property p_switch_new;
        screen_switch_o |-> shown_screen_o != 16'h0000
            && (shown_screen_o != $past(shown_screen_o)
            || $past(host_req_o && host_ack_i && !host_write_o && host_addr_o == ctrl_base_i)
            && shown_screen_o == $past(host_rdata_i));
    endproperty
    property p_quiet;
        !screen_switch_o && !$past(srst_i) |-> $stable(shown_screen_o);
    endproperty
    property p_copy_pulse;
        copy_req_o |=> !copy_req_o;
    endproperty
    property p_copy_src;
        copy_req_o |-> $past(host_req_o && host_ack_i && !host_write_o
            && host_addr_o == ctrl_base_i + 16'h2);
    endproperty
    a_hold: assert property (p_hold) else $error("request changed before ack");
    a_drop: assert property (p_drop) else $error("request not dropped after ack");
    a_next: assert property (p_next) else $error("poll order broken");
    a_pulse: assert property (p_pulse) else $error("switch strobe too long");
    a_switch_new: assert property (p_switch_new) else $error("switch without change");
    a_quiet: assert property (p_quiet) else $error("screen moved silently");
    a_copy_pulse: assert property (p_copy_pulse) else $error("copy strobe too long");
    a_copy_src: assert property (p_copy_src) else $error("copy not after word read");
endmodule

// ===== testbench/tse_host_model.sv
`timescale 1ns/1ns
module tse_host_model
(
    input  wire logic          clock_i,
    input  tse_pkg::tse_word_t notify_base_i,
    input  wire logic          req_i,
    input  wire logic          write_i,
    input  tse_pkg::tse_word_t addr_i,
    input  tse_pkg::tse_word_t wdata_i,
    output logic               ack_o,
    output tse_pkg::tse_word_t rdata_o,
    output logic               done_o
);
    import tse_pkg::*;
    tse_word_t mem [tse_word_t];
    int        wait_n;
    initial
    begin
        ack_o = 1'h0;
        rdata_o = 16'h0000;
        done_o = 1'h0;
        wait_n = 0;
    end
    always @(posedge clock_i)
    begin
        done_o <= !ack_o && req_i && wait_n == 0 && write_i
            && addr_i == notify_base_i + 16'h2;
        if (ack_o || !req_i)
        begin
            ack_o <= 1'h0;
            // released data toggles
            rdata_o <= ~rdata_o;
            wait_n = $urandom_range(2);
        end
        else if (wait_n > 0)
            wait_n--;
        else
        begin
            ack_o <= 1'h1;
            if (write_i)
            begin
                mem[addr_i] = wdata_i;
            end
            else
                rdata_o <= mem[addr_i];
        end
    end
endmodule

// ===== testbench/terminal_status_exchange_bench.sv
`timescale 1ns/1ns
`include "tse_cfg.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("Error at %0t: got %h expected %h", $time, g, e); end end
module terminal_status_exchange_bench;
    import tse_pkg::*;
    localparam tse_word_t CB = 16'h0100, NB = 16'h0110, EA = 16'h0200, KA = 16'h0300;
    logic clock_i = 1'h0, srst_i = 1'h1, menu_valid_i = 1'h0, key_valid_i = 1'h0;
    logic key_numeral_i = 1'h0, host_ack_i, host_req_o, host_write_o, screen_switch_o;
    logic copy_req_o, done;
    tse_word_t ctrl_base_i = CB, notify_base_i = NB, elem_addr_i = EA;
    tse_word_t status_bits_i = 16'h0000, menu_screen_i = 16'h0000, key_table_i = 16'h0000;
    tse_word_t key_addr_i = 16'h0000, key_value_i = 16'h0000, host_rdata_i, host_addr_o;
    tse_word_t host_wdata_o, shown_screen_o, ctrl_bits_o, elem_value_o, stat, v;
    logic [3:0]  copy_type_o;
    logic [11:0] copy_src_o, copy_dst_o;
    int n_mismatch = 0, n_checks = 0, n_copy = 0, n0, n_sw = 0, n_sw0 = 0;
    tse_exchange i_tse_exchange (.*);
    tse_host_model i_host (.clock_i(clock_i), .notify_base_i(notify_base_i),
        .req_i(host_req_o), .write_i(host_write_o), .addr_i(host_addr_o),
        .wdata_i(host_wdata_o), .ack_o(host_ack_i), .rdata_o(host_rdata_i), .done_o(done));
    always #4 clock_i = ~clock_i;
    always @(posedge clock_i) if (copy_req_o === 1'h1) n_copy++;
    always @(posedge clock_i) if (screen_switch_o === 1'h1) n_sw++;
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic round();
        int n;
        n = 0;
        do begin @(posedge clock_i); #1; n++; end while (done !== 1'h1 && n < 3000);
        if (n >= 3000)
        begin
            n_mismatch++;
            wrap_up();
        end
        @(negedge clock_i);
        stat = i_host.mem[NB + 16'h2];
    endtask
    task automatic chk(input tse_word_t scr, input logic b12, input logic b11);
        `CHK(shown_screen_o, scr)
        `CHK(i_host.mem[NB], scr)
        `CHK(stat[`TSE_STB_SCREEN], b12)
        `CHK(stat[`TSE_STB_NUMERAL], b11)
        `CHK(stat & ~`TSE_STB_MASK, status_bits_i & ~`TSE_STB_MASK)
        `CHK(ctrl_bits_o, i_host.mem[CB + 16'h3])
        `CHK(elem_value_o, i_host.mem[EA])
        `CHK(n_sw - n_sw0, b12)
        n_sw0 = n_sw;
        status_bits_i = 16'($urandom);
        i_host.mem[CB + 16'h3] = 16'($urandom);
        i_host.mem[EA] = 16'($urandom);
        $display("round test done at %0t", $time);
    endtask
    task automatic key(input logic num, input tse_word_t t, input tse_word_t a);
        v = 16'($urandom);
        key_numeral_i = num;
        key_table_i = t;
        key_addr_i = a;
        key_value_i = v;
        key_valid_i = 1'h1;
        @(negedge clock_i);
        key_valid_i = 1'h0;
        round();
    endtask
    initial
    begin
        void'($urandom(32'h4529d8b1));
        for (int i = 0; i < 4; i++) i_host.mem[CB + 16'(i)] = 16'h0000;
        for (int i = 0; i < 3; i++) i_host.mem[NB + 16'(i)] = 16'h0000;
        i_host.mem[EA] = 16'h0000;
        repeat (20) @(posedge clock_i);
        @(negedge clock_i);
        srst_i = 1'h0;
        round();
        chk(16'h0000, 1'h0, 1'h0);
        i_host.mem[CB] = 16'h0012;
        round();
        chk(16'h0012, 1'h1, 1'h0);
        round();
        chk(16'h0012, 1'h0, 1'h0);
        i_host.mem[CB] = 16'h0000;
        round();
        chk(16'h0012, 1'h0, 1'h0);
        i_host.mem[CB] = 16'h0012;
        round();
        chk(16'h0012, 1'h1, 1'h0);
        menu_screen_i = 16'h0034;
        menu_valid_i = 1'h1;
        @(negedge clock_i);
        menu_valid_i = 1'h0;
        round();
        chk(16'h0034, 1'h1, 1'h0);
        for (int t = 0; t < 2; t++)
        begin
            n0 = n_copy;
            i_host.mem[CB + 16'h1] = {4'h0, t ? 12'h123 : 12'h905};
            i_host.mem[CB + 16'h2] = {4'(t), t ? 12'h456 : 12'h078};
            round();
            chk(16'h0034, 1'h0, 1'h0);
            `CHK(copy_type_o, 4'(t))
            `CHK(copy_src_o, t ? 12'h123 : 12'h905)
            `CHK(copy_dst_o, t ? 12'h456 : 12'h078)
            `CHK(n_copy - n0, 1)
        end
        key(1'h1, 16'h0007, KA);
        chk(16'h0034, 1'h0, 1'h1);
        `CHK(i_host.mem[KA], v)
        `CHK(i_host.mem[NB + 16'h1], 16'h0007)
        key(1'h0, 16'h0009, KA + 16'h1);
        chk(16'h0034, 1'h0, 1'h0);
        `CHK(i_host.mem[KA + 16'h1], v)
        `CHK(i_host.mem[NB + 16'h1], 16'h0007)
        `CHK(n_copy, 2)
        wrap_up();
    end
    initial
    begin
        #(8 * 1250 * 40);
        n_mismatch++;
        wrap_up();
    end
endmodule
bind tse_exchange tse_checker i_tse_checker (.*);
